// ---- inc/sdram_pkg.sv ----
// constants, field layout and types shared by the synchronous dram device
// Summary of operation
// - read or write may follow every cycle
// - clock-enable change acts one cycle later
// - write byte mask acts in same cycle
// - read byte mask floats outputs two cycles later
// - bank plus row at activate, column at access
// - mode undefined until written, then kept
// - mode bits: length, type, latency, mode, write
// - lengths 1,2,4,8; full page sequential only
// - full page wraps in page until stopped
// - burst wraps inside aligned block of length
// - sequential adds, interleaved xors start offset
// - read latency two or three clocks
// - write burst mode bit makes single writes
package sdram_pkg;

    // ****************************************
    // geometry
    // ****************************************
    localparam int DQ_W     = 16;
    localparam int MASK_W   = 2;
    localparam int ADDR_W   = 12;
    localparam int BANK_W   = 2;
    localparam int NBANK    = 4;
    localparam int COL_W    = 8;
    localparam int IDX_W    = BANK_W + ADDR_W + COL_W;
    localparam int WBUF_W   = IDX_W + MASK_W + DQ_W;
    localparam int WBUF_D   = 8;

    // ****************************************
    // command codes {ras_n, cas_n, we_n}
    // ****************************************
    localparam logic [2:0] CMD_LOAD_MODE = 3'h0;
    localparam logic [2:0] CMD_REFRESH   = 3'h1;
    localparam logic [2:0] CMD_PRECHARGE = 3'h2;
    localparam logic [2:0] CMD_ACTIVE    = 3'h3;
    localparam logic [2:0] CMD_WRITE     = 3'h4;
    localparam logic [2:0] CMD_READ      = 3'h5;
    localparam logic [2:0] CMD_STOP      = 3'h6;
    localparam int         ALL_BANK_BIT  = 10;

    // ****************************************
    // operating_mode_config layout
    // ****************************************
    localparam int         BURST_LEN_LSB   = 0;
    localparam int         BURST_ORDER_POS = 3;
    localparam int         RD_LAT_LSB      = 4;
    localparam int         OP_MODE_LSB     = 7;
    localparam int         WBURST_POS      = 9;
    localparam logic [11:0] MODE_RESET     = 12'h000;
    localparam logic [2:0] BL_1    = 3'h0;
    localparam logic [2:0] BL_2    = 3'h1;
    localparam logic [2:0] BL_4    = 3'h2;
    localparam logic [2:0] BL_8    = 3'h3;
    localparam logic [2:0] BL_PAGE = 3'h7;
    localparam logic [2:0] LAT_2   = 3'h2;
    localparam logic [2:0] LAT_3   = 3'h3;

    // ****************************************
    // latencies in cycles
    // ****************************************
    localparam int cmd_to_cmd_gap           = 1;
    localparam int suspend_entry_lag        = 1;
    localparam int suspend_exit_lag         = 1;
    localparam int write_mask_lag           = 0;
    localparam int read_mask_float_lag      = 2;
    localparam int write_data_lag           = 0;
    localparam int wdata_to_precharge_gap   = 2;
    localparam int last_wdata_to_stop_gap   = 1;
    localparam int last_wdata_to_newcmd_gap = 1;
    localparam int modeload_to_activate_gap = 2;

    typedef enum logic [2:0] {
        BURST_IDLE  = 3'h1,
        BURST_READ  = 3'h2,
        BURST_WRITE = 3'h4
    } burst_state_t;

endpackage

// ---- hw/sdram_wbuf.sv ----
// parameterised valid/ready fifo holding posted write beats
`timescale 1ns/10ps
module sdram_wbuf #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             i_clk,
    input  wire logic             i_nrst,
    input  wire logic             i_ce,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic      [WIDTH-1:0] o_out_data
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [PW:0]      count;
    logic [PW-1:0]    next_wr_ptr;
    logic [PW-1:0]    next_rd_ptr;
    logic [PW:0]      next_count;
    logic             push;
    logic             pop;

    assign o_in_ready  = (count != DEPTH[PW:0]);
    assign o_out_valid = (count != '0);
    assign o_out_data  = store[rd_ptr];
    assign push        = i_ce & i_in_valid & o_in_ready;
    assign pop         = i_ce & i_out_ready & o_out_valid;

    always_comb begin
        next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
        next_count  = count + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
        end
    end

    always_ff @(posedge i_clk) begin
        if (push) begin
            store[wr_ptr] <= i_in_data;
        end
    end
endmodule

// ---- hw/sdram_device.sv ----
// synchronous dram core: commands, mode, bursts, latency and byte masks
`timescale 1ns/10ps
module sdram_device (
    input  wire logic                        i_clk,
    input  wire logic                        i_nrst,
    input  wire logic                        i_ce,
    input  wire logic                        i_cke,
    input  wire logic                        i_cs_n,
    input  wire logic                        i_ras_n,
    input  wire logic                        i_cas_n,
    input  wire logic                        i_we_n,
    input  wire logic                        i_bank_sel_lo,
    input  wire logic                        i_bank_sel_hi,
    input  wire logic [sdram_pkg::ADDR_W-1:0] i_addr,
    input  wire logic [sdram_pkg::MASK_W-1:0] i_dqm,
    input  wire logic [sdram_pkg::DQ_W-1:0]   i_dq,
    output logic      [sdram_pkg::DQ_W-1:0]   o_dq,
    output logic      [sdram_pkg::MASK_W-1:0] o_dq_oe_n,
    output logic                             o_wbuf_ready
);
    import sdram_pkg::*;

    // ****************************************
    // command decode and clock suspend
    // ****************************************
    logic              cke_q;
    logic              run;
    logic [2:0]        cmd;
    logic              cmd_v;
    logic [BANK_W-1:0] cmd_bank;

    // a cke change shows up one edge later because run uses the copy
    assign run      = i_ce & cke_q;
    assign cmd      = {i_ras_n, i_cas_n, i_we_n};
    assign cmd_v    = run & ~i_cs_n;
    assign cmd_bank = {i_bank_sel_hi, i_bank_sel_lo};

    // ****************************************
    // mode register
    // ****************************************
    logic [ADDR_W-1:0] operating_mode_config;
    logic              mode_set;
    logic [ADDR_W-1:0] next_mode;
    logic              next_mode_set;
    logic [2:0]        len_code;
    logic              il_order;
    logic              lat3;
    logic              single_wr;
    logic [COL_W-1:0]  len_mask;
    logic              full_page;

    always_comb begin
        next_mode     = operating_mode_config;
        next_mode_set = mode_set;
        // loaded value kept until the next load
        if (cmd_v && cmd == CMD_LOAD_MODE) begin
            next_mode     = i_addr;
            next_mode_set = 1'b1;
        end
    end

    assign len_code  = operating_mode_config[BURST_LEN_LSB +: 3];
    assign lat3      = operating_mode_config[RD_LAT_LSB +: 3] != LAT_2;
    assign single_wr = operating_mode_config[WBURST_POS];
    assign full_page = (len_code == BL_PAGE);
    // interleaved full page is unsupported, so the page runs sequential
    assign il_order  = operating_mode_config[BURST_ORDER_POS] & ~full_page;

    always_comb begin
        case (len_code)
            BL_2:    len_mask = 8'h01;
            BL_4:    len_mask = 8'h03;
            BL_8:    len_mask = 8'h07;
            BL_PAGE: len_mask = 8'hff;
            default: len_mask = 8'h00;
        endcase
    end

    // ****************************************
    // open row per bank
    // ****************************************
    logic [ADDR_W-1:0] open_row [NBANK];

    generate
        for (genvar b = 0; b < NBANK; b++) begin : g_bank
            logic [ADDR_W-1:0] next_row;
            always_comb begin
                next_row = open_row[b];
                if (cmd_v && cmd == CMD_ACTIVE &&
                    cmd_bank == BANK_W'(b)) begin
                    next_row = i_addr;
                end
            end
            always_ff @(posedge i_clk or negedge i_nrst) begin
                if (!i_nrst) begin
                    open_row[b] <= '0;
                end else if (i_ce) begin
                    open_row[b] <= next_row;
                end
            end
        end
    endgenerate

    // ****************************************
    // burst engine
    // ****************************************
    burst_state_t      state;
    burst_state_t      next_state;
    logic [BANK_W-1:0] b_bank;
    logic [BANK_W-1:0] next_b_bank;
    logic [COL_W-1:0]  b_start;
    logic [COL_W-1:0]  next_b_start;
    logic [COL_W-1:0]  b_cnt;
    logic [COL_W-1:0]  next_b_cnt;
    logic [COL_W-1:0]  b_mask;
    logic [COL_W-1:0]  next_b_mask;
    logic              beat_v;
    logic              beat_rd;
    logic [BANK_W-1:0] beat_bank;
    logic [COL_W-1:0]  beat_col;
    logic              wr_cmd;
    logic              pre_hit;

    // block base from the high column bits, offset from the low ones
    function automatic logic [COL_W-1:0] col_of(
        input logic [COL_W-1:0] start,
        input logic [COL_W-1:0] cnt,
        input logic [COL_W-1:0] mask,
        input logic             il
    );
        logic [COL_W-1:0] off;
        off    = il ? (start ^ cnt) : (start + cnt);
        col_of = (start & ~mask) | (off & mask);
    endfunction

    assign pre_hit = cmd_v && cmd == CMD_PRECHARGE &&
                     (i_addr[ALL_BANK_BIT] || cmd_bank == b_bank);
    assign wr_cmd  = cmd_v && mode_set && cmd == CMD_WRITE;

    always_comb begin
        next_state   = state;
        next_b_bank  = b_bank;
        next_b_start = b_start;
        next_b_cnt   = b_cnt;
        next_b_mask  = b_mask;
        beat_v       = 1'b0;
        beat_rd      = (state == BURST_READ);
        beat_bank    = b_bank;
        beat_col     = col_of(b_start, b_cnt, b_mask, il_order);
        if (run && state != BURST_IDLE) begin
            beat_v     = 1'b1;
            next_b_cnt = b_cnt + 8'h01;
            // full page never ends by itself, it only wraps
            if (b_cnt == b_mask && !full_page) begin
                next_state = BURST_IDLE;
            end
        end
        case (1'b1)
            cmd_v && cmd == CMD_STOP: begin
                beat_v     = 1'b0;
                next_state = BURST_IDLE;
            end
            pre_hit: begin
                beat_v     = 1'b0;
                next_state = BURST_IDLE;
            end
            cmd_v && mode_set && (cmd == CMD_READ || cmd == CMD_WRITE): begin
                // a new access truncates any running burst
                beat_v       = 1'b1;
                beat_rd      = (cmd == CMD_READ);
                beat_bank    = cmd_bank;
                beat_col     = i_addr[COL_W-1:0];
                next_b_bank  = cmd_bank;
                next_b_start = i_addr[COL_W-1:0];
                next_b_cnt   = 8'h01;
                next_b_mask  = (cmd == CMD_WRITE && single_wr) ?
                               8'h00 : len_mask;
                if (next_b_mask == 8'h00) begin
                    next_state = BURST_IDLE;
                end else if (cmd == CMD_READ) begin
                    next_state = BURST_READ;
                end else begin
                    next_state = BURST_WRITE;
                end
            end
            default: begin
            end
        endcase
    end

    // ****************************************
    // write path through the posted buffer
    // ****************************************
    logic               wb_in_v;
    logic               wb_in_rdy;
    logic [WBUF_W-1:0]  wb_in_d;
    logic               wb_out_v;
    logic [WBUF_W-1:0]  wb_out_d;
    logic [IDX_W-1:0]   beat_idx;
    logic [IDX_W-1:0]   wr_idx;
    logic [MASK_W-1:0]  wr_msk;
    logic [DQ_W-1:0]    wr_dat;
    logic               next_wbuf_ready;

    assign beat_idx = {beat_bank, open_row[beat_bank], beat_col};
    // data sits on the pins with the command and every beat; mask is same
    // cycle, and a full buffer drops the beat rather than stall the pins
    assign wb_in_v  = beat_v & ~beat_rd;
    assign wb_in_d  = {beat_idx, i_dqm, i_dq};
    assign {wr_idx, wr_msk, wr_dat} = wb_out_d;
    assign next_wbuf_ready = wb_in_rdy;

    sdram_wbuf #(
        .WIDTH(WBUF_W),
        .DEPTH(WBUF_D)
    ) u_wbuf (
        .i_clk      (i_clk),
        .i_nrst     (i_nrst),
        .i_ce       (i_ce),
        .i_in_valid (wb_in_v),
        .o_in_ready (wb_in_rdy),
        .i_in_data  (wb_in_d),
        .o_out_valid(wb_out_v),
        .i_out_ready(1'b1),
        .o_out_data (wb_out_d)
    );

    // ****************************************
    // storage array
    // ****************************************
    logic [DQ_W-1:0] rd_word;

    generate
        for (genvar i = 0; i < MASK_W; i++) begin : g_lane
            // one array per byte lane keeps every array to a single writer
            logic [7:0] lane_mem [2**IDX_W];
            logic [7:0] lane_rd;
            always_ff @(posedge i_clk) begin
                if (i_ce && wb_out_v && !wr_msk[i]) begin
                    lane_mem[wr_idx] <= wr_dat[i*8 +: 8];
                end
            end
            always_ff @(posedge i_clk) begin
                if (run && beat_v && beat_rd) begin
                    lane_rd <= lane_mem[beat_idx];
                end
            end
            assign rd_word[i*8 +: 8] = lane_rd;
        end
    endgenerate

    // ****************************************
    // read latency pipeline and output
    // ****************************************
    logic              p0_v;
    logic              p1_v;
    logic [DQ_W-1:0]   p1_d;
    logic [MASK_W-1:0] dqm_q;
    logic              next_p0_v;
    logic              next_p1_v;
    logic [DQ_W-1:0]   next_p1_d;
    logic [MASK_W-1:0] next_dqm_q;
    logic [DQ_W-1:0]   next_dq;
    logic [MASK_W-1:0] next_oe_n;
    logic              src_v;
    logic              next_cke_q;

    always_comb begin
        next_cke_q = i_cke;
        next_p0_v  = p0_v;
        next_p1_v  = p1_v;
        next_p1_d  = p1_d;
        next_dqm_q = dqm_q;
        next_dq    = o_dq;
        next_oe_n  = o_dq_oe_n;
        src_v      = lat3 ? p1_v : p0_v;
        // suspended clock freezes the pipe and holds the pins
        if (run) begin
            next_p0_v  = beat_v & beat_rd;
            next_p1_v  = p0_v;
            next_p1_d  = rd_word;
            next_dqm_q = i_dqm;
            // driven at edge n+m-1 so the word is valid by edge n+m
            next_dq    = lat3 ? p1_d : rd_word;
            for (int i = 0; i < MASK_W; i++) begin
                next_oe_n[i] = ~(src_v & ~dqm_q[i]);
            end
            // a write truncating a read frees the bus at once
            if (wr_cmd) begin
                next_p0_v = 1'b0;
                next_p1_v = 1'b0;
                next_oe_n = '1;
            end
        end
    end

    // ****************************************
    // state registers
    // ****************************************
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cke_q                 <= 1'b0;
            operating_mode_config <= MODE_RESET;
            mode_set              <= 1'b0;
            state                 <= BURST_IDLE;
            b_bank                <= '0;
            b_start               <= '0;
            b_cnt                 <= '0;
            b_mask                <= '0;
            p0_v                  <= 1'b0;
            p1_v                  <= 1'b0;
            p1_d                  <= '0;
            dqm_q                 <= '1;
            o_dq                  <= '0;
            o_dq_oe_n             <= '1;
            o_wbuf_ready          <= 1'b0;
        end else if (i_ce) begin
            cke_q                 <= next_cke_q;
            operating_mode_config <= next_mode;
            mode_set              <= next_mode_set;
            state                 <= next_state;
            b_bank                <= next_b_bank;
            b_start               <= next_b_start;
            b_cnt                 <= next_b_cnt;
            b_mask                <= next_b_mask;
            p0_v                  <= next_p0_v;
            p1_v                  <= next_p1_v;
            p1_d                  <= next_p1_d;
            dqm_q                 <= next_dqm_q;
            o_dq                  <= next_dq;
            o_dq_oe_n             <= next_oe_n;
            o_wbuf_ready          <= next_wbuf_ready;
        end
    end
endmodule

// ---- tb/sdram_device_chk.sv ----
// port assertions for the dram device
`timescale 1ns/10ps
module sdram_device_chk (
    input wire logic                         i_clk,
    input wire logic                         i_nrst,
    input wire logic                         i_ce,
    input wire logic                         i_cke,
    input wire logic                         i_cs_n,
    input wire logic                         i_ras_n,
    input wire logic                         i_cas_n,
    input wire logic                         i_we_n,
    input wire logic [sdram_pkg::ADDR_W-1:0] i_addr,
    input wire logic [sdram_pkg::MASK_W-1:0] i_dqm,
    input wire logic [sdram_pkg::DQ_W-1:0]   o_dq,
    input wire logic [sdram_pkg::MASK_W-1:0] o_dq_oe_n,
    input wire logic                         o_wbuf_ready
);
    import sdram_pkg::*;
    // ****
    // command decode shadow
    // ****
    logic        cke_q;
    logic        loaded;
    logic [11:0] mode;
    logic        live, rd, wr, quiet, lat2;
    assign live  = i_ce && cke_q && !i_cs_n;
    assign rd    = live && {i_ras_n, i_cas_n, i_we_n} == CMD_READ && loaded;
    assign wr    = live && {i_ras_n, i_cas_n, i_we_n} == CMD_WRITE;
    assign quiet = i_ce && i_cke && i_cs_n;
    assign lat2  = mode[6:4] == LAT_2;
    // shadow of the mode so read checks know length and latency
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cke_q <= 1'b0;
            loaded <= 1'b0;
            mode <= MODE_RESET;
        end else if (i_ce) begin
            cke_q <= i_cke;
            if (live && {i_ras_n, i_cas_n, i_we_n} == CMD_LOAD_MODE) begin
                loaded <= 1'b1;
                mode <= i_addr;
            end
        end
    end
    // ****
    // assertions
    // ****
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    a_wr_floats: assert property (wr |=> o_dq_oe_n == 2'h3)
        else $error("write left outputs driven");
    a_mask_float: assert property (
        i_dqm == 2'h3 && i_ce && cke_q ##1 i_ce && cke_q
        |=> o_dq_oe_n == 2'h3)
        else $error("masked read byte driven");
    a_rd_lat3: assert property (
        rd && i_cke && !lat2 ##1 quiet && i_dqm == 2'h0 ##1 quiet
        |=> o_dq_oe_n == 2'h0)
        else $error("latency three word missing");
    a_burst_span: assert property (
        rd && i_cke && lat2 && mode[2:0] == BL_2 && i_dqm == 2'h0
        ##1 (quiet && i_dqm == 2'h0)[*3]
        |=> o_dq_oe_n == 2'h3 && $past(o_dq_oe_n) == 2'h0)
        else $error("two word burst span wrong");
    a_page_runs: assert property (
        rd && i_cke && lat2 && mode[2:0] == BL_PAGE
        ##1 (quiet && i_dqm == 2'h0)[*8] |=> o_dq_oe_n == 2'h0)
        else $error("page burst stopped early");
    a_unloaded_quiet: assert property (!loaded |-> o_dq_oe_n == 2'h3)
        else $error("driven before mode load");
    a_wbuf_ready: assert property (i_ce |=> o_wbuf_ready)
        else $error("write buffer not ready");
    a_cke_freeze: assert property (
        i_ce && !i_cke |=> ##1 $stable(o_dq_oe_n) && $stable(o_dq))
        else $error("outputs moved while suspended");
endmodule
bind sdram_device sdram_device_chk sdram_device_chk_inst (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_ce(i_ce), .i_cke(i_cke),
    .i_cs_n(i_cs_n), .i_ras_n(i_ras_n), .i_cas_n(i_cas_n), .i_we_n(i_we_n),
    .i_addr(i_addr), .i_dqm(i_dqm), .o_dq(o_dq), .o_dq_oe_n(o_dq_oe_n),
    .o_wbuf_ready(o_wbuf_ready)
);

// ---- tb/sdram_ctrl_model.sv ----
// behavioural memory controller driving the dram command pins
`timescale 1ns/10ps
module sdram_ctrl_model #(
    parameter int INIT_CYC = 5000
) (
    input  wire logic                         i_clk,
    output logic                              o_cke,
    output logic                              o_cs_n,
    output logic                              o_ras_n,
    output logic                              o_cas_n,
    output logic                              o_we_n,
    output logic                              o_bank_sel_lo,
    output logic                              o_bank_sel_hi,
    output logic [sdram_pkg::ADDR_W-1:0]      o_addr,
    output logic [sdram_pkg::MASK_W-1:0]      o_dqm,
    output logic [sdram_pkg::DQ_W-1:0]        o_dq
);
    import sdram_pkg::*;
    // ****
    // command sequencing
    // ****
    initial begin
        o_cke = 1'b1;
        o_cs_n = 1'b1;
        {o_ras_n, o_cas_n, o_we_n} = 3'h7;
        {o_bank_sel_hi, o_bank_sel_lo} = 2'h0;
        o_addr = 12'h000;
        o_dqm = 2'h3;
        o_dq = 16'h0000;
    end
    task automatic drive(input logic cs_n, input logic [2:0] cmd,
                         input logic [1:0] bank, input logic [11:0] a,
                         input logic [1:0] m, input logic [15:0] d);
        @(posedge i_clk);
        #1;
        o_cs_n = cs_n;
        {o_ras_n, o_cas_n, o_we_n} = cmd;
        {o_bank_sel_hi, o_bank_sel_lo} = bank;
        o_addr = a;
        o_dqm = m;
        o_dq = d;
    endtask
    // released data lines toggle so stale values never look valid
    task automatic nop(input logic [1:0] m);
        drive(1'b1, 3'h7, {o_bank_sel_hi, o_bank_sel_lo}, o_addr, m, ~o_dq);
    endtask
    task automatic init();
        repeat (INIT_CYC) nop(2'h3);
    endtask
    task automatic setup(input logic [11:0] m, input int refs);
        drive(1'b0, CMD_PRECHARGE, 2'h0, 12'h400, 2'h0, ~o_dq);
        repeat (3) nop(2'h0);
        repeat (refs) begin
            drive(1'b0, CMD_REFRESH, 2'h0, 12'h000, 2'h0, ~o_dq);
            repeat (4) nop(2'h0);
        end
        drive(1'b0, CMD_LOAD_MODE, 2'h0, m, 2'h0, ~o_dq);
        repeat (2) nop(2'h0);
        drive(1'b0, CMD_ACTIVE, 2'h3, 12'h005, 2'h0, ~o_dq);
        repeat (2) nop(2'h0);
    endtask
    task automatic suspend(input int n);
        o_cke = 1'b0;
        repeat (n) nop(2'h0);
        o_cke = 1'b1;
    endtask
endmodule

// ---- tb/sdram_init_mode_burst_bench.sv ----
// self-checking bench for the dram device: mode, bursts and masks
`timescale 1ns/10ps
`define CHK(nm, e, g) \
    compares++; \
    if ((g) !== (e)) begin \
        num_errors++; \
        $display("mismatch %s exp %h got %h", nm, e, g); \
    end
module sdram_init_mode_burst_bench;
    import sdram_pkg::*;
    logic              clk = 1'b0;
    logic              nrst = 1'b0;
    logic              ce = 1'b1;
    logic              cke, cs_n, ras_n, cas_n, we_n, bs_lo, bs_hi, wrdy;
    logic [ADDR_W-1:0] addr;
    logic [MASK_W-1:0] dqm, oe_n;
    logic [DQ_W-1:0]   dq_in, dq_out;
    logic [DQ_W-1:0]   mem [256];
    int                num_errors = 0;
    int                compares = 0;
    int                cyc = 0;

    always #10 clk = ~clk;

    sdram_device sdram_device_inst (
        .i_clk(clk), .i_nrst(nrst), .i_ce(ce), .i_cke(cke), .i_cs_n(cs_n),
        .i_ras_n(ras_n), .i_cas_n(cas_n), .i_we_n(we_n),
        .i_bank_sel_lo(bs_lo), .i_bank_sel_hi(bs_hi), .i_addr(addr),
        .i_dqm(dqm), .i_dq(dq_in), .o_dq(dq_out), .o_dq_oe_n(oe_n),
        .o_wbuf_ready(wrdy)
    );
    sdram_ctrl_model sdram_ctrl_model_inst (
        .i_clk(clk), .o_cke(cke), .o_cs_n(cs_n), .o_ras_n(ras_n),
        .o_cas_n(cas_n), .o_we_n(we_n), .o_bank_sel_lo(bs_lo),
        .o_bank_sel_hi(bs_hi), .o_addr(addr), .o_dqm(dqm), .o_dq(dq_in)
    );
    // ****
    // helpers
    // ****
    function automatic int col_of(int s, int i, int bl, bit il);
        int off;
        off = s % bl;
        if (il)
            return s - off + (off ^ i);
        return s - off + ((off + i) % bl);
    endfunction
    function automatic logic [11:0] mv(bit wb, logic [2:0] lat, bit il,
                                       logic [2:0] bl);
        return {2'h0, wb, 2'h0, lat, il, bl};
    endfunction
    // beat mk has its low byte masked; the mirror keeps the old byte
    task automatic wr(int s, int n, int bl, bit il, logic [15:0] b, int mk);
        logic [15:0] d;
        logic [1:0]  m;
        int          c;
        for (int i = 0; i < n; i++) begin
            d = b + 16'(i);
            m = (i == mk) ? 2'h1 : 2'h0;
            c = col_of(s, i, bl, il);
            mem[c][15:8] = d[15:8];
            if (i != mk)
                mem[c][7:0] = d[7:0];
            sdram_ctrl_model_inst.drive(i != 0, (i == 0) ? CMD_WRITE : 3'h7,
                2'h3, 12'(s), m, d);
        end
        if (bl == 256)
            sdram_ctrl_model_inst.drive(1'b0, CMD_STOP, 2'h3, 12'(s),
                2'h0, ~d);
        repeat (2) sdram_ctrl_model_inst.nop(2'h0);
    endtask
    task automatic rd(int s, int n, int bl, bit il, int lat);
        sdram_ctrl_model_inst.drive(1'b0, CMD_READ, 2'h3, 12'(s), 2'h0,
            ~dq_in);
        for (int i = 1; i < lat + n; i++) begin
            sdram_ctrl_model_inst.nop(2'h0);
            if (i >= lat) begin
                `CHK("rdata", mem[col_of(s, i - lat, bl, il)], dq_out)
                `CHK("rdrive", 2'h0, oe_n)
            end
        end
        if (bl < 256) begin
            sdram_ctrl_model_inst.nop(2'h0);
            `CHK("rdone", 2'h3, oe_n)
        end
    endtask
    // ****
    // scenarios
    // ****
    task automatic t_seq_mask();
        sdram_ctrl_model_inst.setup(mv(1'b0, LAT_2, 1'b0, BL_4), 2);
        wr(0, 4, 4, 1'b0, 16'h1000, 9);
        wr(2, 4, 4, 1'b0, 16'h2000, 1);
        rd(0, 4, 4, 1'b0, 2);
    endtask
    task automatic t_interleave();
        sdram_ctrl_model_inst.setup(mv(1'b0, LAT_3, 1'b1, BL_8), 0);
        wr(5, 8, 8, 1'b1, 16'h3000, 9);
        rd(0, 8, 8, 1'b1, 3);
    endtask
    // toggling data after the single beat would land in column 0 if burst
    task automatic t_single_write();
        sdram_ctrl_model_inst.setup(mv(1'b1, LAT_2, 1'b0, BL_2), 0);
        wr(1, 1, 2, 1'b0, 16'h4000, 9);
        rd(0, 2, 2, 1'b0, 2);
    endtask
    task automatic t_page();
        logic [15:0] w;
        sdram_ctrl_model_inst.setup(mv(1'b0, LAT_2, 1'b0, BL_PAGE), 0);
        wr(254, 4, 256, 1'b0, 16'h5000, 9);
        rd(254, 10, 256, 1'b0, 2);
        rd(0, 1, 256, 1'b0, 2);
        // a running page burst must hold its word while the block is frozen
        w = dq_out;
        ce = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        `CHK("hold", w, dq_out)
        ce = 1'b1;
        repeat (3) sdram_ctrl_model_inst.nop(2'h3);
        `CHK("float", 2'h3, oe_n)
        sdram_ctrl_model_inst.suspend(2);
        sdram_ctrl_model_inst.drive(1'b0, CMD_STOP, 2'h1, 12'h0, 2'h0, 16'h0);
        repeat (2) sdram_ctrl_model_inst.nop(2'h0);
    endtask
    // ****
    // run control
    // ****
    task automatic end_sim();
        $display("compares %0d errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk);
        #1 nrst = 1'b1;
        sdram_ctrl_model_inst.init();
        t_seq_mask();
        t_interleave();
        t_single_write();
        t_page();
        end_sim();
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 8000) begin
            num_errors++;
            end_sim();
        end
    end
endmodule
